/* File: blo_logic_unit.sv */
// boolean builder, delay, polarity and drive mode of one logic output pin
`timescale 1ns/1ps
`include "blo_regs.svh"
module blo_logic_unit (
  input  wire logic                    sys_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    msTick,
  input  wire logic [`BLO_OPERANDS-1:0] operands,
  input  wire logic [`BLO_OPERANDS-1:0] selA,
  input  wire logic [`BLO_OPERANDS-1:0] invA,
  input  wire logic [`BLO_OPERANDS-1:0] selB,
  input  wire logic [`BLO_OPERANDS-1:0] invB,
  input  wire logic [31:0]             ctrl,
  output logic                         logicState,
  output logic                         pinOut,
  output logic                         pinOe
);
  logic                          usedA, usedB, termA, termB, raw, needDly, level;
  logic                          target;
  logic [15:0]                   msCnt;
  blo_pkg::blo_dly_state_type    state;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // each path ands its selected operands after inversion
  assign usedA = |selA; // RQ12
  assign usedB = |selB; // RQ12
  assign termA = &(~selA | (operands ^ invA)); // RQ7 RQ12
  assign termB = &(~selB | (operands ^ invB)); // RQ7 RQ12

  // top gate over the two paths; an empty path drops out of the gate
  always_comb begin
    case (ctrl[`BLO_F_GATE]) // RQ5 RQ6
      2'(blo_pkg::BLO_GATE_OR):  raw = (usedA & termA) | (usedB & termB);
      2'(blo_pkg::BLO_GATE_NOR): raw = (usedA | usedB) & ~((usedA & termA) | (usedB & termB));
      default:                   raw = (usedA | usedB) & (~usedA | termA) & (~usedB | termB);
    endcase
  end

  assign needDly = (raw ? ctrl[`BLO_F_DLY_ASSERT] : ctrl[`BLO_F_DLY_DEASSERT])
                   && ctrl[`BLO_F_DELAY_MS] != 16'h0000; // RQ11

  // delay engine: unless inputs are ignored, a new result must stand for the whole count
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state      <= blo_pkg::BLO_IDLE;
      logicState <= 1'b0;
      target     <= 1'b0;
      msCnt      <= 16'h0000;
    end else begin
      case (state)
        blo_pkg::BLO_IDLE: begin
          if (raw != logicState) begin
            if (needDly) begin // RQ11
              state  <= blo_pkg::BLO_WAIT;
              target <= raw;
              msCnt  <= 16'h0000;
            end else begin
              logicState <= raw;
            end
          end
        end
        blo_pkg::BLO_WAIT: begin
          if (!ctrl[`BLO_F_IGNORE] && raw != target) begin
            state <= blo_pkg::BLO_IDLE; // RQ11 RQ13
          end else if (msTick) begin
            if (msCnt + 16'h0001 >= ctrl[`BLO_F_DELAY_MS]) begin // RQ13
              logicState <= target;
              state      <= blo_pkg::BLO_IDLE;
            end else begin
              msCnt <= msCnt + 16'h0001;
            end
          end
        end
        default: state <= blo_pkg::BLO_IDLE;
      endcase
    end
  end

  // polarity then drive mode; open drain never drives high
  assign level = ~(logicState ^ ctrl[`BLO_F_POLARITY]); // RQ9
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pinOut <= 1'b0;
      pinOe  <= 1'b0;
    end else begin
      pinOut <= ctrl[`BLO_F_OPEN_DRAIN] ? 1'b0 : level; // RQ10
      pinOe  <= ctrl[`BLO_F_OPEN_DRAIN] ? ~level : 1'b1; // RQ10
    end
  end

  a_and_all_true: assert property ( // RQ12
    ctrl[`BLO_F_GATE] == 2'(blo_pkg::BLO_GATE_AND) && usedA && !usedB && termA |-> raw)
    else $error("and path with all operands true gave false");
  a_polarity_level: assert property ( // RQ9
    !ctrl[`BLO_F_OPEN_DRAIN] |=> pinOe && pinOut == ($past(logicState) ~^ $past(ctrl[`BLO_F_POLARITY])))
    else $error("driven pin level disagrees with polarity");
  a_open_drain_release: assert property ( // RQ10
    ctrl[`BLO_F_OPEN_DRAIN] && level |=> !pinOe && !pinOut)
    else $error("open drain pin driven while high");
  a_delay_holds: assert property ( // RQ13
    state == blo_pkg::BLO_WAIT && !msTick |=> $stable(logicState))
    else $error("delayed output changed between ticks");
  a_no_delay_follow: assert property ( // RQ11
    state == blo_pkg::BLO_IDLE && raw != logicState && !needDly |=> logicState == $past(raw))
    else $error("undelayed result not taken next cycle");
  a_ignore_inputs: assert property ( // RQ11
    state == blo_pkg::BLO_WAIT && ctrl[`BLO_F_IGNORE] && !msTick |=> state == blo_pkg::BLO_WAIT)
    else $error("delay dropped while inputs ignored");
endmodule // blo_logic_unit

/* File: blo_output_pins.sv */
// logic output block: command outputs, sixteen boolean outputs, latched status, axi4-lite registers
`timescale 1ns/1ps
`include "blo_regs.svh"
module blo_output_pins #(
  parameter int TICK_CYCLES = `BLO_TICK_CYCLES
) (
  input  wire logic                        sys_clk,
  input  wire logic                        sys_rst,
  input  wire logic [11:0]                 s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [11:0]                 s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic [31:0]                 generalInput,
  input  wire logic [31:0]                 railEnablePin,
  input  wire logic [`BLO_STATUS_BITS-1:0] railStatus,
  output logic [`BLO_CMD_PINS-1:0]         generalOutput,
  output logic [`BLO_CMD_PINS-1:0]         generalOutputOe,
  output logic [`BLO_LOGIC_PINS-1:0]       logicOutputPin,
  output logic [`BLO_LOGIC_PINS-1:0]       logicOutputPinOe
);
  logic [31:0]                  gpiSync;
  logic [`BLO_LOGIC_PINS-1:0]   logicState;
  logic [`BLO_STATUS_BITS-1:0]  latchedStatus;
  logic [`BLO_OPERANDS-1:0]     operands;
  logic [2:0]                   cmdCfg [0:`BLO_CMD_PINS-1];
  logic [6:0]                   cmdSelect;
  logic [5:0]                   clrPinCfg;
  logic [31:0]                  logicCtrl [0:`BLO_LOGIC_PINS-1];
  logic [31:0]                  maskMem [0:255];
  logic [11:0]                  awAddr;
  logic [31:0]                  wData;
  logic [3:0]                   wStrb;
  logic                         awHeld, wHeld, doWrite, wrHit;
  logic                         next_awHeld, next_wHeld, next_bvalid, next_rvalid;
  logic [31:0]                  rdValue;
  logic                         rdHit;
  logic [31:0]                  merged;
  logic [15:0]                  tickCnt;
  logic                         msTick;
  logic                         pinClear;
  logic [`BLO_STATUS_BITS-1:0]  statusClr;

  // pins from outside the clock domain
  blo_sync #(.W(32)) u_gpi_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pinIn   (generalInput),
    .pinSync (gpiSync)
  );

  // operand order: inputs, logic outputs, enables, live status, latched status
  assign operands = {latchedStatus, railStatus, railEnablePin, logicState, gpiSync}; // RQ7

  // millisecond tick shared by all delay engines
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tickCnt <= 16'h0000;
      msTick  <= 1'b0;
    end else begin
      msTick  <= tickCnt == 16'(TICK_CYCLES - 1); // RQ13
      tickCnt <= (tickCnt == 16'(TICK_CYCLES - 1)) ? 16'h0000 : tickCnt + 16'h0001;
    end
  end

  // axi write channel bookkeeping; address and data taken in either order
  assign doWrite     = awHeld && wHeld && !s_axi_bvalid;
  assign next_awHeld = (awHeld || (s_axi_awvalid && s_axi_awready)) && !doWrite;
  assign next_wHeld  = (wHeld || (s_axi_wvalid && s_axi_wready)) && !doWrite;
  assign next_bvalid = doWrite || (s_axi_bvalid && !s_axi_bready);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `BLO_RESP_OKAY;
      awAddr        <= 12'h000;
      wData         <= 32'h0000_0000;
      wStrb         <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) awAddr <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) begin
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) s_axi_bresp <= wrHit ? `BLO_RESP_OKAY : `BLO_RESP_SLVERR;
      awHeld        <= next_awHeld;
      wHeld         <= next_wHeld;
      s_axi_bvalid  <= next_bvalid;
      // one write in flight: each ready only while its own channel holds nothing and no response is pending
      s_axi_awready <= !next_awHeld && !next_bvalid && !(awHeld && !doWrite);
      s_axi_wready  <= !next_wHeld && !next_bvalid && !(wHeld && !doWrite);
    end
  end

  // whether a write lands in a mapped word
  always_comb begin
    wrHit = 1'b1;
    if (awAddr[11:10] == `BLO_MASK_BASE) wrHit = 1'b1;
    else if (awAddr[11:6] == `BLO_CTRL_BASE) wrHit = 1'b1;
    else if (awAddr == `BLO_SELECT_OFS || awAddr == `BLO_CONFIG_OFS || awAddr == `BLO_LATCH_OFS
             || awAddr == `BLO_CLRPIN_OFS || awAddr == `BLO_STATE_OFS) wrHit = 1'b1;
    else wrHit = 1'b0;
  end

  // byte-lane merge for the word being written
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) if (st[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    return r;
  endfunction

  assign merged = lane_merge(32'h0000_0000, wData, wStrb);

  // pin select, clear-pin setup and per-pin control words
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cmdSelect <= 7'h00;
      clrPinCfg <= 6'h00;
      for (int p = 0; p < `BLO_LOGIC_PINS; p++) logicCtrl[p] <= `BLO_CTRL_RST;
    end else if (doWrite) begin
      if (awAddr == `BLO_SELECT_OFS && wStrb[0]) cmdSelect <= wData[6:0];
      if (awAddr == `BLO_CLRPIN_OFS && wStrb[0]) clrPinCfg <= wData[5:0];
      if (awAddr[11:6] == `BLO_CTRL_BASE)
        logicCtrl[awAddr[5:2]] <= lane_merge(logicCtrl[awAddr[5:2]], wData, wStrb); // RQ5 RQ9 RQ10 RQ11
    end
  end

  // operand select and invert masks, two paths per pin
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int m = 0; m < 256; m++) maskMem[m] <= 32'h0000_0000;
    end else if (doWrite && awAddr[11:10] == `BLO_MASK_BASE) begin
      maskMem[awAddr[9:2]] <= lane_merge(maskMem[awAddr[9:2]], wData, wStrb); // RQ7
    end
  end

  // command outputs: configure acts on the selected pin only
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int c = 0; c < `BLO_CMD_PINS; c++) cmdCfg[c] <= 3'h0;
    end else if (doWrite && awAddr == `BLO_CONFIG_OFS && wStrb[0] && cmdSelect < 7'(`BLO_CMD_PINS)) begin
      cmdCfg[cmdSelect] <= wData[2:0]; // RQ1 RQ2
    end
  end

  // latched status: a new event beats a clear in the same cycle
  assign pinClear  = clrPinCfg[`BLO_CLR_ENABLE] && gpiSync[clrPinCfg[4:0]];
  assign statusClr = {`BLO_STATUS_BITS{pinClear}}
                   | ((doWrite && awAddr == `BLO_LATCH_OFS) ? merged[`BLO_STATUS_BITS-1:0] : '0);
  always_ff @(posedge sys_clk) begin
    if (sys_rst) latchedStatus <= '0;
    else latchedStatus <= (latchedStatus & ~statusClr) | railStatus; // RQ8
  end

  // per-pin command output flops
  genvar gi;
  generate
    for (gi = 0; gi < `BLO_CMD_PINS; gi++) begin : g_cmd
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          generalOutput[gi]   <= 1'b0;
          generalOutputOe[gi] <= 1'b0;
        end else begin
          generalOutput[gi]   <= cmdCfg[gi][`BLO_CMD_LEVEL]; // RQ2
          generalOutputOe[gi] <= cmdCfg[gi][`BLO_CMD_OWNED] && cmdCfg[gi][`BLO_CMD_DRIVE]; // RQ1 RQ2
        end
      end
    end
  endgenerate

  // one boolean unit per logic output pin
  generate
    for (gi = 0; gi < `BLO_LOGIC_PINS; gi++) begin : g_logic
      blo_logic_unit u_unit ( // RQ3 RQ4
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .msTick     (msTick),
        .operands   (operands),
        .selA       ({maskMem[gi*16+3], maskMem[gi*16+2], maskMem[gi*16+1], maskMem[gi*16]}),
        .invA       ({maskMem[gi*16+7], maskMem[gi*16+6], maskMem[gi*16+5], maskMem[gi*16+4]}),
        .selB       ({maskMem[gi*16+11], maskMem[gi*16+10], maskMem[gi*16+9], maskMem[gi*16+8]}),
        .invB       ({maskMem[gi*16+15], maskMem[gi*16+14], maskMem[gi*16+13], maskMem[gi*16+12]}),
        .ctrl       (logicCtrl[gi]),
        .logicState (logicState[gi]),
        .pinOut     (logicOutputPin[gi]),
        .pinOe      (logicOutputPinOe[gi])
      );
    end
  endgenerate

  // read mux; unmapped words read zero with slverr
  always_comb begin
    rdValue = 32'h0000_0000;
    rdHit   = 1'b1;
    if (s_axi_araddr[11:10] == `BLO_MASK_BASE) rdValue = maskMem[s_axi_araddr[9:2]];
    else if (s_axi_araddr[11:6] == `BLO_CTRL_BASE) rdValue = logicCtrl[s_axi_araddr[5:2]];
    else if (s_axi_araddr == `BLO_SELECT_OFS) rdValue = {25'h0, cmdSelect};
    else if (s_axi_araddr == `BLO_CONFIG_OFS)
      rdValue = (cmdSelect < 7'(`BLO_CMD_PINS)) ? {29'h0, cmdCfg[cmdSelect]} : 32'h0000_0000;
    else if (s_axi_araddr == `BLO_LATCH_OFS) rdValue = {8'h00, latchedStatus};
    else if (s_axi_araddr == `BLO_CLRPIN_OFS) rdValue = {26'h0, clrPinCfg};
    else if (s_axi_araddr == `BLO_STATE_OFS) rdValue = {16'h0000, logicState};
    else rdHit = 1'b0;
  end

  // read channel: data registered the cycle after the address is taken
  assign next_rvalid = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `BLO_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rdata <= rdValue;
        s_axi_rresp <= rdHit ? `BLO_RESP_OKAY : `BLO_RESP_SLVERR;
      end
      s_axi_rvalid  <= next_rvalid;
      s_axi_arready <= !next_rvalid;
    end
  end

  a_cfg_drives_pin: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ2
    doWrite && awAddr == `BLO_CONFIG_OFS && wStrb[0] && cmdSelect < 7'(`BLO_CMD_PINS) |=> ##1
      generalOutputOe[$past(cmdSelect, 2)] == ($past(wData[2], 2) && $past(wData[1], 2))
      && generalOutput[$past(cmdSelect, 2)] == $past(wData[0], 2))
    else $error("command pin does not follow its configuration");
  a_unowned_floats: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ1
    !cmdCfg[0][`BLO_CMD_OWNED] |=> !generalOutputOe[0])
    else $error("pin not under command is driven");
  a_latch_holds: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ8
    latchedStatus[0] && !statusClr[0] |=> latchedStatus[0])
    else $error("latched status dropped without a clear");
  a_latch_sets: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ8
    railStatus[0] |=> latchedStatus[0])
    else $error("status event not latched");
endmodule // blo_output_pins

/* File: blo_pin_load.sv */
// pin-side load model: pull-downs on command pins, pull-ups on logic pins
`timescale 1ns/1ps
`include "blo_regs.svh"
module blo_pin_load (
  input  wire logic [`BLO_CMD_PINS-1:0]   cmdLevel,
  input  wire logic [`BLO_CMD_PINS-1:0]   cmdOe,
  input  wire logic [`BLO_LOGIC_PINS-1:0] logicLevel,
  input  wire logic [`BLO_LOGIC_PINS-1:0] logicOe,
  output logic      [`BLO_CMD_PINS-1:0]   cmdWire,
  output logic      [`BLO_LOGIC_PINS-1:0] logicWire
);
  // released command pins read low through the led pull-down
  assign cmdWire = cmdOe & cmdLevel;
  // open drain needs a pull-up, so a released logic pin reads high
  assign logicWire = (logicOe & logicLevel) | ~logicOe;
endmodule // blo_pin_load

/* File: blo_pkg.sv */
// types shared by the logic output block
package blo_pkg;
  typedef enum logic [1:0] {BLO_GATE_AND, BLO_GATE_OR, BLO_GATE_NOR} blo_gate_type;
  typedef enum logic {BLO_IDLE, BLO_WAIT} blo_dly_state_type;
endpackage

/* File: blo_regs.svh */
// register offsets, field positions, reset values and timing counts of the logic output block
// What this block does
// RQ1 - any of 84 pins can be command output
// RQ2 - command output: low, high or high-impedance
// RQ3 - sixteen dedicated logic output pins exist
// RQ4 - each logic pin has own boolean unit
// RQ5 - top gate AND/OR/NOR, optional delay
// RQ6 - top gate takes two AND paths
// RQ7 - AND path selects inputs, outputs, enables, statuses
// RQ8 - latched status holds until command/pin clears
// RQ9 - polarity picks high or low when true
// RQ10 - driven or open-drain; high releases pin
// RQ11 - delay on assert/deassert, optional input ignore
// RQ12 - AND of selected inverted operands; empty skipped
// RQ13 - delay counted in millisecond ticks, result held
`ifndef BLO_REGS_SVH
`define BLO_REGS_SVH

`define BLO_CMD_PINS    84
`define BLO_LOGIC_PINS  16
`define BLO_STATUS_BITS 24
`define BLO_OPERANDS    128

`define BLO_SELECT_OFS  12'h000
`define BLO_CONFIG_OFS  12'h004
`define BLO_LATCH_OFS   12'h008
`define BLO_CLRPIN_OFS  12'h00c
`define BLO_STATE_OFS   12'h010
`define BLO_CTRL_BASE   6'h02
`define BLO_MASK_BASE   2'h1

`define BLO_CMD_LEVEL   0
`define BLO_CMD_DRIVE   1
`define BLO_CMD_OWNED   2
`define BLO_CLR_ENABLE  5
`define BLO_F_GATE      1:0
`define BLO_F_DLY_ASSERT 2
`define BLO_F_DLY_DEASSERT 3
`define BLO_F_IGNORE    4
`define BLO_F_POLARITY  5
`define BLO_F_OPEN_DRAIN 6
`define BLO_F_DELAY_MS  31:16

`define BLO_CTRL_RST    32'h0000_0020
`define BLO_RESP_OKAY   2'h0
`define BLO_RESP_SLVERR 2'h2

`define BLO_CLK_NS      25
`define BLO_MS_NS       1000000
`define BLO_TICK_CYCLES (`BLO_MS_NS / `BLO_CLK_NS)

`endif

/* File: blo_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module blo_sync #(
  parameter int W = 32
) (
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinSync
);
  logic [W-1:0] stage1;

  // first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stage1  <= '0;
      pinSync <= '0;
    end else begin
      stage1  <= pinIn;
      pinSync <= stage1;
    end
  end
endmodule // blo_sync

/* File: boolean_logic_output_pins_tb.sv */
// self-checking bench of the logic output block
`timescale 1ns/1ps
`include "blo_regs.svh"
module boolean_logic_output_pins_tb;
  logic        sys_clk = 1'h0;
  logic        sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, generalInput, railEnablePin, rngState;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [23:0] railStatus;
  logic [83:0] generalOutput, generalOutputOe, cmdWire;
  logic [15:0] logicOutputPin, logicOutputPinOe, logicWire;
  logic [33:0] expRead[$];
  logic [1:0]  expWrite[$];
  int          n_fail = 0;
  int          samples_checked = 0;

  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  // four cycles per ms keeps delays short
  blo_output_pins #(.TICK_CYCLES(4)) uut (
    .sys_clk(sys_clk), .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .generalInput(generalInput),
    .railEnablePin(railEnablePin), .railStatus(railStatus), .generalOutput(generalOutput),
    .generalOutputOe(generalOutputOe), .logicOutputPin(logicOutputPin),
    .logicOutputPinOe(logicOutputPinOe));

  blo_pin_load load (.cmdLevel(generalOutput), .cmdOe(generalOutputOe), .logicLevel(logicOutputPin),
    .logicOe(logicOutputPinOe), .cmdWire(cmdWire), .logicWire(logicWire));

  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h wanted %h", $time, seen, want);
    end
  endtask

  task automatic report_and_stop();
    if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // xorshift source, fixed start
  function automatic logic [31:0] rnd();
    rngState ^= rngState << 13;
    rngState ^= rngState >> 17;
    rngState ^= rngState << 5;
    return rngState;
  endfunction

  function automatic logic gateEval(input logic [1:0] g, input logic a, input logic b);
    case (g)
      2'h1: return a | b;
      2'h2: return !(a | b);
      default: return a & b;
    endcase
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // address and data offered together; bready held until the response
  // no cycle limit here: only the watchdog may end a wait for the answer
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    expWrite.push_back(r);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask

  task automatic axi_read(input logic [11:0] a, input logic [33:0] w);
    expRead.push_back(w);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    axi_write(a, d, 4'hf, 2'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d);
    axi_read(a, {2'h0, d});
  endtask

  // one input pulse on logic pin 2, counting cycles the pin stands high
  task automatic pulse_watch(output int highs);
    highs = 0;
    generalInput[8] <= 1'h1;
    tick(4);
    generalInput[8] <= 1'h0;
    repeat (24) begin
      @(posedge sys_clk);
      highs += int'(logicOutputPin[2] === 1'h1);
    end
  endtask

  // responses are matched against the oldest note at each handshake
  always @(posedge sys_clk) begin
    if (s_axi_bvalid && s_axi_bready) check({32'h0, s_axi_bresp}, {32'h0, expWrite.pop_front()});
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, expRead.pop_front());
  end

  // watchdog well above the expected run
  initial begin
    tick(30000);
    n_fail++;
    report_and_stop();
  end

  initial begin
    logic [6:0]  pin;
    logic [2:0]  mode;
    logic [31:0] gi, en, st, r;
    logic        res, lvl;
    int          highs;
    rngState = 32'h2798;
    sys_rst = 1'h1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
    {generalInput, railEnablePin, railStatus} = 88'h0;
    tick(16);
    sys_rst <= 1'h0;
    tick(2);
    // reset state: control words and idle driven-low logic pins
    for (int p = 0; p < 16; p++) rd(12'h080 + 12'(4 * p), 32'h20);
    check({2'h0, logicWire, logicOutputPinOe}, {2'h0, 16'h0, 16'hffff});
    axi_write(12'h08c, 32'h1234_5661, 4'h1, 2'h0);
    axi_write(12'h08c, 32'h0005_0000, 4'hc, 2'h0);
    rd(12'h08c, 32'h0005_0061);
    wr(12'h08c, 32'h20);
    axi_write(12'h020, 32'h1, 4'hf, 2'h2);
    axi_read(12'h020, {2'h2, 32'h0});
    // command pins: both range ends and random ones, every state
    for (int i = 0; i < 5; i++) begin
      pin = (i == 0) ? 7'h0 : (i == 1) ? 7'h53 : 7'(rnd() % 82 + 1);
      wr(`BLO_SELECT_OFS, {25'h0, pin});
      // last mode asks to drive high on a pin not under command: it must float
      for (int m = 0; m < 4; m++) begin
        mode = (m == 2) ? 3'h4 : (m == 3) ? 3'h3 : {2'h3, m[0]};
        wr(`BLO_CONFIG_OFS, {29'h0, mode});
        tick(3);
        check({32'h0, cmdWire[pin], generalOutputOe[pin]}, {32'h0, &mode, mode[2] & mode[1]});
        rd(`BLO_CONFIG_OFS, {29'h0, mode});
      end
    end
    wr(`BLO_SELECT_OFS, 32'h54);
    wr(`BLO_CONFIG_OFS, 32'h7);
    rd(`BLO_CONFIG_OFS, 32'h0);
    // pin 1: path a = inputs 3:0 with bit 1 inverted, path b = enable 0 and status 0
    wr(12'h440, 32'hf);
    wr(12'h450, 32'h2);
    wr(12'h464, 32'h1_0000);
    wr(12'h468, 32'h1_0000);
    for (int i = 0; i < 28; i++) begin
      if (i == 24) begin
        wr(12'h464, 32'h0);
        wr(12'h468, 32'h0);
      end
      gi = rnd();
      en = rnd();
      st = rnd();
      r = rnd();
      generalInput <= gi;
      railEnablePin <= en;
      railStatus <= st[23:0];
      wr(12'h084, {25'h0, r[1], r[0], 3'h0, 2'(i % 4)});
      tick(6);
      res = gateEval(2'(i % 4), &(gi[3:0] ^ 4'h2), (i >= 24) ? &(gi[3:0] ^ 4'h2) : en[0] & st[0]);
      lvl = r[0] ? res : !res;
      check({32'h0, logicWire[1], logicOutputPinOe[1]}, {32'h0, lvl, !(r[1] & lvl)});
      rd(`BLO_STATE_OFS, {16'h0, 14'h0, res, 1'h0});
    end
    // pin 2: 3 ms delay on assertion only
    generalInput <= 32'h0;
    railStatus <= 24'h0;
    wr(12'h480, 32'h100);
    wr(12'h088, 32'h0003_0024);
    generalInput[8] <= 1'h1;
    tick(4);
    check({33'h0, logicOutputPin[2]}, 34'h0);
    tick(16);
    check({33'h0, logicOutputPin[2]}, 34'h1);
    generalInput[8] <= 1'h0;
    tick(6);
    check({33'h0, logicOutputPin[2]}, 34'h0);
    pulse_watch(highs);
    check({33'h0, highs != 0}, 34'h0);
    wr(12'h088, 32'h0003_0034);
    pulse_watch(highs);
    check({33'h0, highs != 0}, 34'h1);
    // delay on deassertion only: pin outlasts the short pulse by whole ticks
    wr(12'h088, 32'h0003_0028);
    pulse_watch(highs);
    check({33'h0, highs > 8}, 34'h1);
    // latched status: event sets, write-one and the chosen input clear
    wr(`BLO_LATCH_OFS, 32'h00ff_ffff);
    rd(`BLO_LATCH_OFS, 32'h0);
    railStatus[5] <= 1'h1;
    tick(1);
    railStatus[5] <= 1'h0;
    tick(3);
    rd(`BLO_LATCH_OFS, 32'h20);
    wr(`BLO_LATCH_OFS, 32'h20);
    rd(`BLO_LATCH_OFS, 32'h0);
    wr(`BLO_CLRPIN_OFS, 32'h29);
    railStatus[7] <= 1'h1;
    tick(1);
    railStatus[7] <= 1'h0;
    tick(3);
    rd(`BLO_LATCH_OFS, 32'h80);
    generalInput[9] <= 1'h1;
    tick(4);
    generalInput[9] <= 1'h0;
    tick(3);
    rd(`BLO_LATCH_OFS, 32'h0);
    report_and_stop();
  end
endmodule // boolean_logic_output_pins_tb
